// File: rtl/psr_regs.sv
// Status, identifier and advertisement registers of the embedded transceiver.
// Assumes requests and conditions come from logic on the same core clock.

// Notes on behaviour
// R1 - Status bit 15 always reads zero
// R2 - Status bits 14 to 11 read one
// R3 - Status bits 10 to 7 read zero
// R4 - Bit 6 zero; preamble-less frames refused
// R5 - Bit 5 shows negotiation complete
// R6 - Bit 4 latches remote fault, read clears
// R7 - Status bit 3 always reads one
// R8 - Bit 2 link status, latch low
// R9 - Bit 1 latches jabber high
// R10 - Status bit 0 always reads one
// R11 - Identifier high holds organisation bits 3-18
// R12 - Identifier low: organisation, model, revision fields
// R13 - Advertise bit 15 always reads zero
// R14 - Advertise bit 14 shows partner acknowledge
// R15 - Advertise bit 13 writable remote fault
// R16 - Advertise bit 10 writable pause
// R17 - Advertise bit 9 zero, writes ignored
// R18 - Advertise bits 8-5 writable, reset one
// R19 - Advertise selector writable, reset 00001
// R20 - Host reaches registers via vendor commands
// R21 - Latched bits return live after read
module psr_regs #(
	// Arbitrary neutral identity values
	parameter logic [15:0] ORG_CODE_UPPER = 16'h1234,
	parameter logic [5:0] ORG_CODE_LOWER = 6'h15,
	parameter logic [5:0] MODEL_NUMBER = 6'h2A,
	parameter logic [3:0] MODEL_REVISION = 4'h3
) (
	input wire logic clk,
	input wire logic nrst,
	input wire psr_pkg::psr_req_t req,
	input wire psr_pkg::psr_cond_t cond,
	output logic ack_q,
	output logic [15:0] rdata_q,
	output logic [15:0] advertise_q,
	output logic preamble_required_q
);

	logic rs_fault_q;
	logic jabber_q;
	logic link_q;
	logic an_done_q;
	logic rs_fault_d;
	logic jabber_d;
	logic link_d;

	logic remote_fault_adv_q;
	logic pause_adv_q;
	logic [3:0] abil_adv_q;
	logic [4:0] selector_q;
	logic lp_ack_q;

	// Next values, one per register
	logic an_done_d;
	logic lp_ack_d;
	logic remote_fault_adv_d;
	logic pause_adv_d;
	logic [3:0] abil_adv_d;
	logic [4:0] selector_d;
	logic ack_d;
	logic [15:0] rdata_d;
	logic [15:0] advertise_d;
	logic preamble_required_d;

	// R20
	// Vendor read and write decode
	wire hit_status = req.addr == psr_pkg::OFS_BASIC_STATUS;
	wire hit_id_high = req.addr == psr_pkg::OFS_IDENTIFIER_HIGH;
	wire hit_id_low = req.addr == psr_pkg::OFS_IDENTIFIER_LOW;
	wire hit_adv = req.addr == psr_pkg::OFS_NEGOTIATION_ADVERTISE;
	wire rd_status = req.valid && !req.write && hit_status;
	wire wr_adv = req.valid && req.write && hit_adv;
	wire rd_any = req.valid && !req.write;
	// Write data split into the writable advertise fields
	wire rf_wdata = req.wdata[psr_pkg::AD_REMOTE_FAULT];
	wire pause_wdata = req.wdata[psr_pkg::AD_PAUSE];
	wire [3:0] abil_wdata = req.wdata[psr_pkg::AD_ABIL_HI:psr_pkg::AD_ABIL_LO];
	wire [4:0] sel_wdata = req.wdata[psr_pkg::AD_SEL_HI:psr_pkg::AD_SEL_LO];

	// R6 R9 R21
	// Event in the read cycle survives the clear
	assign rs_fault_d = cond.remote_fault | (rd_status ? 1'b0 : rs_fault_q);
	assign jabber_d = cond.jabber | (rd_status ? 1'b0 : jabber_q);
	// R8 R21
	// Drop in the read cycle is still caught
	assign link_d = cond.link_up & (rd_status ? 1'b1 : link_q);

	wire [15:0] status_word;
	// R1 four-pair mode absent
	assign status_word[psr_pkg::ST_FOUR_PAIR] = 1'b0;
	// R2 one permanent bit per ability
	genvar gi;
	generate
		for (gi = psr_pkg::ST_CAP_LO; gi <= psr_pkg::ST_CAP_HI; gi++)
		begin : g_cap
			assign status_word[gi] = 1'b1;
		end
	endgenerate
	// R3 reserved reads zero
	assign status_word[psr_pkg::ST_RSV_HI:psr_pkg::ST_RSV_LO] = 4'h0;
	// R4 no preamble suppression
	assign status_word[psr_pkg::ST_NO_PREAMBLE] = 1'b0;
	// R5 negotiation complete
	assign status_word[psr_pkg::ST_AN_DONE] = an_done_q;
	// R6 latched remote fault
	assign status_word[psr_pkg::ST_REMOTE_FAULT] = rs_fault_q;
	// R7 negotiation ability
	assign status_word[psr_pkg::ST_AN_ABLE] = 1'b1;
	// R8 latched link status
	assign status_word[psr_pkg::ST_LINK] = link_q;
	// R9 latched jabber
	assign status_word[psr_pkg::ST_JABBER] = jabber_q;
	// R10 extended registers present
	assign status_word[psr_pkg::ST_EXTENDED] = 1'b1;

	// R11 R12
	wire [15:0] id_high_word = ORG_CODE_UPPER;
	wire [15:0] id_low_word = {ORG_CODE_LOWER, MODEL_NUMBER, MODEL_REVISION};

	wire [15:0] adv_word;
	// R13 R17
	assign adv_word[psr_pkg::AD_NEXT_PAGE] = 1'b0;
	// R14
	assign adv_word[psr_pkg::AD_ACK] = lp_ack_q;
	assign adv_word[psr_pkg::AD_REMOTE_FAULT] = remote_fault_adv_q;
	// Reserved field reads zero, writes dropped
	assign adv_word[12:11] = 2'h0;
	assign adv_word[psr_pkg::AD_PAUSE] = pause_adv_q;
	assign adv_word[psr_pkg::AD_FOUR_PAIR] = 1'b0;
	assign adv_word[psr_pkg::AD_ABIL_HI:psr_pkg::AD_ABIL_LO] = abil_adv_q;
	assign adv_word[psr_pkg::AD_SEL_HI:psr_pkg::AD_SEL_LO] = selector_q;

	// Unmapped offsets read zero
	wire [15:0] read_mux = hit_status ? status_word :
		hit_id_high ? id_high_word :
		hit_id_low ? id_low_word :
		hit_adv ? adv_word : psr_pkg::ZERO_WORD;

	// R5 R14
	// Live conditions are registered once, no latching
	assign an_done_d = cond.an_done;
	assign lp_ack_d = cond.lp_ack;

	// R15 R16
	// Only a write to the advertise offset moves these
	assign remote_fault_adv_d = wr_adv ? rf_wdata : remote_fault_adv_q;
	assign pause_adv_d = wr_adv ? pause_wdata : pause_adv_q;
	// R18 R19
	assign abil_adv_d = wr_adv ? abil_wdata : abil_adv_q;
	assign selector_d = wr_adv ? sel_wdata : selector_q;

	// R20
	// Every request is answered, read or write, any offset
	assign ack_d = req.valid;
	// Read data holds between reads so a slow host can still pick it up
	assign rdata_d = rd_any ? read_mux : rdata_q;
	// Registered copy of the word for the transceiver core
	assign advertise_d = adv_word;
	// R4
	// Preamble-less management frames are always refused
	assign preamble_required_d = 1'b1;

	// R6 R21 remote fault latch
	// Held high until a status read; set wins over clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rs_fault_q <= 1'b0;
		end
		else
		begin
			rs_fault_q <= rs_fault_d;
		end
	end

	// R9 R21 jabber latch
	// Same latch-high shape as remote fault
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			jabber_q <= 1'b0;
		end
		else
		begin
			jabber_q <= jabber_d;
		end
	end

	// R8 R21 link latch-low
	// Reads low after reset until a read sees link
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			link_q <= 1'b0;
		end
		else
		begin
			link_q <= link_d;
		end
	end

	// R5 negotiation complete
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			an_done_q <= 1'b0;
		end
		else
		begin
			an_done_q <= an_done_d;
		end
	end

	// R14 partner acknowledge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lp_ack_q <= 1'b0;
		end
		else
		begin
			lp_ack_q <= lp_ack_d;
		end
	end

	// R15 advertised remote fault
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			remote_fault_adv_q <= 1'b0;
		end
		else
		begin
			remote_fault_adv_q <= remote_fault_adv_d;
		end
	end

	// R16 advertised pause
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pause_adv_q <= 1'b0;
		end
		else
		begin
			pause_adv_q <= pause_adv_d;
		end
	end

	// R18 advertised abilities, reset one
	// Host may withdraw any speed before renegotiating
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			abil_adv_q <= psr_pkg::RST_ABILITIES;
		end
		else
		begin
			abil_adv_q <= abil_adv_d;
		end
	end

	// R19 protocol selector
	// Any code is kept; the core decides what it accepts
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			selector_q <= psr_pkg::RST_SELECTOR;
		end
		else
		begin
			selector_q <= selector_d;
		end
	end

	// R20 answer strobe
	// One cycle after each request, never stretched
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_q <= 1'b0;
		end
		else
		begin
			ack_q <= ack_d;
		end
	end

	// R20 read data
	// Holds until the next read
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_q <= psr_pkg::ZERO_WORD;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// R13 R17 advertise copy
	// Fixed bits come from the word, never from writes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			advertise_q <= psr_pkg::RST_ADVERTISE;
		end
		else
		begin
			advertise_q <= advertise_d;
		end
	end

	// R4 preamble required
	// Constant, kept as a flop so the output is registered
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			preamble_required_q <= 1'b1;
		end
		else
		begin
			preamble_required_q <= preamble_required_d;
		end
	end

endmodule

// File: rtl/psr_pkg.sv
// Constants and carrier types for the transceiver status, identifier and advertisement registers.
// Assumes a single core clock and register accesses issued by the vendor-command engine.
package psr_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [4:0] OFS_BASIC_STATUS = 5'h01;
	localparam logic [4:0] OFS_IDENTIFIER_HIGH = 5'h02;
	localparam logic [4:0] OFS_IDENTIFIER_LOW = 5'h03;
	localparam logic [4:0] OFS_NEGOTIATION_ADVERTISE = 5'h04;

	// Status bit positions
	localparam int ST_FOUR_PAIR = 15;
	localparam int ST_CAP_HI = 14;
	localparam int ST_CAP_LO = 11;
	localparam int ST_RSV_HI = 10;
	localparam int ST_RSV_LO = 7;
	localparam int ST_NO_PREAMBLE = 6;
	localparam int ST_AN_DONE = 5;
	localparam int ST_REMOTE_FAULT = 4;
	localparam int ST_AN_ABLE = 3;
	localparam int ST_LINK = 2;
	localparam int ST_JABBER = 1;
	localparam int ST_EXTENDED = 0;

	// Advertisement bit positions
	localparam int AD_NEXT_PAGE = 15;
	localparam int AD_ACK = 14;
	localparam int AD_REMOTE_FAULT = 13;
	localparam int AD_PAUSE = 10;
	localparam int AD_FOUR_PAIR = 9;
	localparam int AD_ABIL_HI = 8;
	localparam int AD_ABIL_LO = 5;
	localparam int AD_SEL_HI = 4;
	localparam int AD_SEL_LO = 0;

	// Identifier field positions
	localparam int ID_ORG_LO_HI = 15;
	localparam int ID_ORG_LO_LO = 10;
	localparam int ID_MODEL_HI = 9;
	localparam int ID_MODEL_LO = 4;
	localparam int ID_REV_HI = 3;
	localparam int ID_REV_LO = 0;

	// Values after reset
	localparam logic [3:0] RST_ABILITIES = 4'hF;
	localparam logic [4:0] RST_SELECTOR = 5'h01;
	localparam logic [15:0] RST_ADVERTISE = 16'h01E1;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	// Live conditions reported by the transceiver core
	typedef struct packed {
		logic link_up;
		logic an_done;
		logic remote_fault;
		logic jabber;
		logic lp_ack;
	} psr_cond_t;

	// One register access from the vendor-command engine
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] addr;
		logic [15:0] wdata;
	} psr_req_t;

endpackage

// File: tb/psr_regs_assertions.sv
// Port assertions, psr_regs.
// Bound to every instance.
module psr_regs_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire psr_pkg::psr_req_t req,
	input wire psr_pkg::psr_cond_t cond,
	input wire logic ack_q,
	input wire logic [15:0] rdata_q,
	input wire logic [15:0] advertise_q,
	input wire logic preamble_required_q
);
	timeunit 1ns/1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence st_rd;
		req.valid && !req.write && req.addr == 5'h01;
	endsequence
	ack_pulse_a: assert property (req.valid |=> ack_q) else $error("ack");
	st_fixed_a: assert property (st_rd |=> (rdata_q & 16'hFFC9) == 16'h7809) else $error("st");
	pre_on_a: assert property (preamble_required_q) else $error("pre");
	ad_fixed_a: assert property (!advertise_q[15] && !advertise_q[9]) else $error("ad");
	jab_latch_a: assert property (cond.jabber ##1 st_rd |=> rdata_q[1]) else $error("jab");
	link_low_a: assert property (!cond.link_up ##1 st_rd |=> !rdata_q[2]) else $error("link");
	an_done_a: assert property (st_rd |=> rdata_q[5] == ($past(cond.an_done, 2) && $past(nrst, 2))) else $error("an");
	ad_write_a: assert property (req.valid && req.write && req.addr == 5'h04 |=> ##1
		(advertise_q & 16'h25FF) == ($past(req.wdata, 2) & 16'h25FF)) else $error("wr");
	ack_idle_a: assert property (!req.valid |=> !ack_q) else $error("ack idle");
	rf_latch_a: assert property (cond.remote_fault ##1 st_rd |=> rdata_q[4]) else $error("rf");
	jab_clear_a: assert property ((req.valid && !req.write && req.addr == 5'h01 && !cond.jabber) ##1
		!cond.jabber ##1 st_rd |=> !rdata_q[1]) else $error("jab clear");
endmodule
bind psr_regs psr_regs_chk psr_regs_chk_inst (.clk, .nrst, .req, .cond, .ack_q, .rdata_q, .advertise_q,
	.preamble_required_q);

// File: tb/psr_host.sv
// Host model: register commands.
// Expects a reply one cycle on.
module psr_host (
	input wire logic clk,
	output psr_pkg::psr_req_t req,
	input wire logic ack_q,
	input wire logic [15:0] rdata_q
);
	timeunit 1ns/1ns;
	initial req = '0;
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] r);
		@(negedge clk);
		req <= '{1'b1, w, a, d};
		@(negedge clk);
		r = ack_q ? rdata_q : 16'hXXXX;
		// Released fields carry junk
		req <= '{1'b0, ~w, ~a, ~d};
	endtask
endmodule

// File: tb/tb_top.sv
// Bench for psr_regs.
// Host model does the accesses.
module tb_top;
	timeunit 1ns/1ns;
	logic clk = 1'b0, nrst = 1'b0, ack_q, preamble_required_q;
	logic [15:0] rdata_q, r, advertise_q;
	psr_pkg::psr_cond_t cond = '0;
	psr_pkg::psr_req_t req;
	int fail_count = 0, checked = 0;
	always #5 clk = ~clk;
	psr_regs psr_regs_inst (.clk, .nrst, .req, .cond, .ack_q, .rdata_q, .advertise_q, .preamble_required_q);
	psr_host psr_host_inst (.clk, .req, .ack_q, .rdata_q);
	task automatic rc(input logic [4:0] a, input logic [15:0] e);
		psr_host_inst.acc(1'b0, a, 16'h0000, r);
		checked++;
		if (r !== e)
		begin
			fail_count++;
			$display("ERROR rdata exp %h got %h", e, r);
		end
	endtask
	task automatic cv(input logic [15:0] e);
		checked++;
		if (advertise_q !== e)
		begin
			fail_count++;
			$display("ERROR advertise_q exp %h got %h", e, advertise_q);
		end
	endtask
	task automatic cp(input logic e);
		checked++;
		if (preamble_required_q !== e)
		begin
			fail_count++;
			$display("ERROR preamble_required_q exp %h got %h", e, preamble_required_q);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_reset();
		cv(16'h01E1);
		cp(1'b1);
		rc(5'h01, 16'h7809);
		rc(5'h02, 16'h1234);
		rc(5'h03, 16'h56A3);
		rc(5'h04, 16'h01E1);
		rc(5'h1F, 16'h0000);
	endtask
	task automatic t_latch();
		cond = '1;
		rc(5'h01, 16'h783B);
		cond.jabber = 1'b0;
		cond.remote_fault = 1'b0;
		rc(5'h01, 16'h783F);
		rc(5'h01, 16'h782D);
		cond.link_up = 1'b0;
		rc(5'h01, 16'h7829);
		cond.link_up = 1'b1;
		rc(5'h01, 16'h7829);
		rc(5'h04, 16'h41E1);
	endtask
	task automatic t_write();
		psr_host_inst.acc(1'b1, 5'h04, 16'hFFFF, r);
		rc(5'h04, 16'h65FF);
		cv(16'h65FF);
		psr_host_inst.acc(1'b1, 5'h02, 16'h0000, r);
		rc(5'h02, 16'h1234);
	endtask
	task automatic t_mid_reset();
		psr_host_inst.acc(1'b1, 5'h04, 16'h0000, r);
		@(negedge clk);
		cv(16'h4000);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		cv(16'h01E1);
		cp(1'b1);
		rc(5'h04, 16'h41E1);
		rc(5'h01, 16'h7829);
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_latch();
		t_write();
		t_mid_reset();
		finish_test();
	end
endmodule
